// [design/sra_codec_ctrl.sv]
// Codec end: serial slave, parameter registers and activity detectors.
//
// Functional notes
// - Device is slave only, never drives clock.
// - Master shifts on fall, device samples rise.
// - Device shifts on fall, master samples rise.
// - Two bytes each way, MSB first, simultaneous.
// - Select stays low across whole transaction.
// - Master waits 125 ns before first fall.
// - Select held two clocks after last rise.
// - Serial clock at most half system clock.
// - Read opcode 110 returns addressed register.
// - Write opcode 100 stores second byte.
// - Writes accepted at any time.
// - Two detectors: ADC samples, serial input samples.
// - Shared off/on times, separate thresholds.
// - Zero parameter disables detector, output high.
// - Threshold versus top eight bits of magnitude.
// - One comparison per frame sync.
// - Low output counts loud samples to on-time.
// - High output counts quiet samples to off-time.
// - Loopback still feeds the DAC-side detector.
// - Software picks sensible times and thresholds.
// - Power bit lets low DAC flag sleep DAC.
`timescale 1ns/1ns
`default_nettype none
module sra_codec_ctrl (
    input  wire logic                      sys_clk_i,
    input  wire logic                      reset_i,
    sra_spi_if.dev                         spi,
    input  wire logic                      frame_sync_i,
    input  wire logic [sra_pkg::SAMPLE_W-1:0] adc_sample_i,
    input  wire logic [sra_pkg::SAMPLE_W-1:0] serial_audio_in_i,
    input  wire logic                      loopback_i,
    output logic                           adc_activity_flag_o,
    output logic                           dac_activity_flag_o,
    output logic                           dac_power_down_o,
    output logic                           dac_data_valid_o,
    output logic [sra_pkg::SAMPLE_W-1:0]   dac_data_o
);
    import sra_pkg::*;

    typedef struct packed {
        logic [2:0]                 sck_sync;
        logic [1:0]                 ss_sync;
        logic [1:0]                 mosi_sync;
        logic [1:0]                 fs_sync;
        logic                       fs_prev;
        logic [CNT_W-1:0]           bit_cnt;
        logic [FRAME_BITS-1:0]      shift_in;
        logic [BYTE_W-1:0]          shift_out;
        logic                       miso;
        logic [BYTE_W-1:0]          off_lo;
        logic [BYTE_W-1:0]          off_hi;
        logic [BYTE_W-1:0]          on_time;
        logic [BYTE_W-1:0]          adc_thr;
        logic [BYTE_W-1:0]          dac_thr;
        logic [BYTE_W-1:0]          power;
        logic [1:0]                 flag;
        logic [1:0][FRAME_BITS-1:0] run;
        logic                       dac_pd;
        logic                       dac_vld;
        logic [SAMPLE_W-1:0]        dac_data;
    } sra_dev_state_s;

    sra_dev_state_s st;
    sra_dev_state_s next_st;

    function automatic logic [BYTE_W-1:0] mag_top(input logic [SAMPLE_W-1:0] s);
        logic [SAMPLE_W-1:0] a;
        a = s[SAMPLE_W-1] ? SAMPLE_W'(~s + 1'b1) : s;
        return a[SAMPLE_W-2 -: BYTE_W];
    endfunction : mag_top

    function automatic logic [BYTE_W-1:0] reg_read(input logic [ADDR_W-1:0] a,
                                                   input sra_dev_state_s s);
        logic [BYTE_W-1:0] r;
        r = REG_RESET;
        unique case (a)
            ADR_OFF_LO:  r = s.off_lo;
            ADR_OFF_HI:  r = s.off_hi;
            ADR_ON_TIME: r = s.on_time;
            ADR_ADC_THR: r = s.adc_thr;
            ADR_DAC_THR: r = s.dac_thr;
            ADR_POWER:   r = s.power;
            default:     r = REG_RESET;
        endcase
        return r;
    endfunction : reg_read

    logic                  sck_rise;
    logic                  sck_fall;
    logic                  sel;
    logic [FRAME_BITS-1:0] word;
    logic [FRAME_BITS-1:0] off_time;
    logic [BYTE_W-1:0]     thr [2];
    logic [SAMPLE_W-1:0]   smp [2];
    logic                  enabled;
    logic                  loud;
    logic                  quiet;

    // ********************************************************************
    // Next-state logic
    // ********************************************************************
    always_comb begin
        next_st = st;
        next_st.sck_sync  = {st.sck_sync[1:0], spi.sck};
        next_st.ss_sync   = {st.ss_sync[0], spi.ss_n};
        next_st.mosi_sync = {st.mosi_sync[0], spi.mosi};
        next_st.fs_sync   = {st.fs_sync[0], frame_sync_i};
        next_st.fs_prev   = st.fs_sync[1];
        // Clock only sampled, never driven here, so it must stay slow.
        sck_rise = st.sck_sync[1] & ~st.sck_sync[2];
        sck_fall = ~st.sck_sync[1] & st.sck_sync[2];
        sel      = ~st.ss_sync[1];
        word     = {st.shift_in[FRAME_BITS-2:0], st.mosi_sync[1]};
        off_time = {st.off_hi, st.off_lo};
        thr[0]   = st.adc_thr;
        thr[1]   = st.dac_thr;
        smp[0]   = adc_sample_i;
        smp[1]   = serial_audio_in_i;
        enabled  = 1'b0;
        loud     = 1'b0;
        quiet    = 1'b0;

        if (!sel) begin
            next_st.bit_cnt = '0;
            next_st.miso    = 1'b0;
        end else begin
            if (sck_rise && st.bit_cnt < CNT_W'(FRAME_BITS)) begin
                next_st.shift_in = word;
                next_st.bit_cnt  = st.bit_cnt + 1'b1;
                if (st.bit_cnt == CNT_W'(BYTE_W - 1) &&
                    word[OP_HI:OP_LO] == OP_READ) begin
                    next_st.shift_out =
                        reg_read(word[ADDR_W-1:0], st);
                end
                if (st.bit_cnt == CNT_W'(FRAME_BITS - 1) &&
                    word[BYTE_W+OP_HI:BYTE_W+OP_LO] == OP_WRITE) begin
                    // Writes land whenever a frame ends; audio keeps running.
                    unique case (word[BYTE_W+ADDR_W-1:BYTE_W])
                        ADR_OFF_LO:  next_st.off_lo  = word[BYTE_W-1:0];
                        ADR_OFF_HI:  next_st.off_hi  = word[BYTE_W-1:0];
                        ADR_ON_TIME: next_st.on_time = word[BYTE_W-1:0];
                        ADR_ADC_THR: next_st.adc_thr = word[BYTE_W-1:0];
                        ADR_DAC_THR: next_st.dac_thr = word[BYTE_W-1:0];
                        ADR_POWER:   next_st.power   = word[BYTE_W-1:0];
                        default:     next_st.power   = st.power;
                    endcase
                end
            end
            if (sck_fall && st.bit_cnt >= CNT_W'(BYTE_W) &&
                st.bit_cnt < CNT_W'(FRAME_BITS)) begin
                next_st.miso      = st.shift_out[BYTE_W-1];
                next_st.shift_out = {st.shift_out[BYTE_W-2:0], 1'b0};
            end
        end

        // Samples are taken on the synchronised rising edge of frame sync.
        next_st.dac_vld = 1'b0;
        if (st.fs_sync[1] && !st.fs_prev) begin
            if (!loopback_i) begin
                next_st.dac_vld  = 1'b1;
                next_st.dac_data = serial_audio_in_i;
            end
            for (int i = 0; i < 2; i++) begin
                enabled = (thr[i] != '0) && (st.on_time != '0) &&
                          (off_time != '0);
                loud  = mag_top(smp[i]) > thr[i];
                quiet = mag_top(smp[i]) < thr[i];
                if (!enabled) begin
                    next_st.flag[i] = 1'b1;
                    next_st.run[i]  = '0;
                end else if (!st.flag[i]) begin
                    if (!loud) begin
                        next_st.run[i] = '0;
                    end else if (st.run[i] + 1'b1 >= {8'h00, st.on_time}) begin
                        next_st.flag[i] = 1'b1;
                        next_st.run[i]  = '0;
                    end else begin
                        next_st.run[i] = st.run[i] + 1'b1;
                    end
                end else begin
                    if (!quiet) begin
                        next_st.run[i] = '0;
                    end else if (st.run[i] + 1'b1 >= off_time) begin
                        next_st.flag[i] = 1'b0;
                        next_st.run[i]  = '0;
                    end else begin
                        next_st.run[i] = st.run[i] + 1'b1;
                    end
                end
            end
        end else begin
            // Disable takes effect at once, not only at the next sample.
            for (int i = 0; i < 2; i++) begin
                if (thr[i] == '0 || st.on_time == '0 || off_time == '0) begin
                    next_st.flag[i] = 1'b1;
                    next_st.run[i]  = '0;
                end
            end
        end
        next_st.dac_pd = st.power[PWR_DAC_SLEEP_BIT] & ~next_st.flag[1];
    end

    // ********************************************************************
    // State register
    // ********************************************************************
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st      <= '0;
            st.ss_sync <= 2'h3;
            st.sck_sync <= 3'h7;
            st.flag <= 2'h3;
        end else begin
            st <= next_st;
        end
    end

    assign spi.miso            = st.miso;
    assign adc_activity_flag_o = st.flag[0];
    assign dac_activity_flag_o = st.flag[1];
    assign dac_power_down_o    = st.dac_pd;
    assign dac_data_valid_o    = st.dac_vld;
    assign dac_data_o          = st.dac_data;
endmodule : sra_codec_ctrl
`default_nettype wire

// [design/sra_pkg.sv]
// Shared constants for the codec control port and activity detectors.
package sra_pkg;
    // ********************************************************************
    // Link framing
    // ********************************************************************
    localparam int unsigned BYTE_W       = 8;
    localparam int unsigned ADDR_W       = 5;
    localparam int unsigned FRAME_BITS   = 16;
    localparam int unsigned CNT_W        = 5;
    localparam logic [2:0]  OP_READ      = 3'h6;
    localparam logic [2:0]  OP_WRITE     = 3'h4;
    localparam int unsigned OP_HI        = 7;
    localparam int unsigned OP_LO        = 5;
    // ********************************************************************
    // Device register addresses
    // ********************************************************************
    localparam logic [4:0]  ADR_OFF_LO   = 5'h0b;
    localparam logic [4:0]  ADR_OFF_HI   = 5'h0c;
    localparam logic [4:0]  ADR_ON_TIME  = 5'h0d;
    localparam logic [4:0]  ADR_ADC_THR  = 5'h0e;
    localparam logic [4:0]  ADR_DAC_THR  = 5'h0f;
    localparam logic [4:0]  ADR_POWER    = 5'h08;
    localparam int unsigned PWR_DAC_SLEEP_BIT = 4;
    localparam logic [7:0]  REG_RESET    = 8'h00;
    // ********************************************************************
    // Sample format and timing
    // ********************************************************************
    localparam int unsigned SAMPLE_W     = 16;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned T_RECOVER_NS = 125;
    localparam int unsigned RECOVER_CYC  =
        (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DISABLE_CYC  = 2;
    // ********************************************************************
    // Host command port addresses
    // ********************************************************************
    localparam logic [1:0]  HADR_CMD     = 2'h0;
    localparam logic [1:0]  HADR_STATUS  = 2'h1;
    localparam logic [1:0]  HADR_RDATA   = 2'h2;
    localparam int unsigned CMD_DATA_LO  = 0;
    localparam int unsigned CMD_ADDR_LO  = 8;
    localparam int unsigned CMD_RD_BIT   = 13;
endpackage : sra_pkg

// [design/sra_spi_if.sv]
// Four-wire serial control link between host master and codec slave.
`timescale 1ns/1ns
`default_nettype none
interface sra_spi_if;
    logic sck;
    logic ss_n;
    logic mosi;
    logic miso;
    modport host (output sck, output ss_n, output mosi, input miso);
    modport dev  (input sck, input ss_n, input mosi, output miso);
endinterface : sra_spi_if
`default_nettype wire

// [design/sra_spi_host.sv]
// Host end: register-port driven serial master with divided clock.
`timescale 1ns/1ns
`default_nettype none
module sra_spi_host #(
    parameter int unsigned HALF_DIV = 4
) (
    input  wire logic                       sys_clk_i,
    input  wire logic                       reset_i,
    input  wire logic [1:0]                 addr_i,
    input  wire logic [15:0]                wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic      [15:0]                rdata_o,
    sra_spi_if.host                         spi
);
    import sra_pkg::*;

    // Under four cycles a half period the synchronised answer arrives late.
    if (HALF_DIV < 4 || HALF_DIV > 255 - DISABLE_CYC) begin : g_bad_div
        $error("HALF_DIV out of range");
    end

    typedef enum logic [2:0] {IDLE, SETUP, LOW, HIGH, HOLD} sra_host_e;

    typedef struct packed {
        sra_host_e             fsm;
        logic [7:0]            div;
        logic [CNT_W-1:0]      bits;
        logic [FRAME_BITS-1:0] tx;
        logic [BYTE_W-1:0]     rx;
        logic [1:0]            miso_sync;
        logic [1:0]            cap;
        logic                  busy;
        logic                  is_read;
        logic                  sck;
        logic                  ss_n;
        logic                  mosi;
        logic [15:0]           rdata;
    } sra_host_state_s;

    sra_host_state_s st;
    sra_host_state_s next_st;

    // ********************************************************************
    // Next-state logic
    // ********************************************************************
    always_comb begin
        next_st = st;
        next_st.miso_sync = {st.miso_sync[0], spi.miso};
        next_st.cap = {st.cap[0], 1'b0};
        next_st.rdata = '0;
        if (rd_i) begin
            unique case (addr_i)
                HADR_STATUS: next_st.rdata = {15'h0000, st.busy};
                HADR_RDATA:  next_st.rdata = {8'h00, st.rx};
                default:     next_st.rdata = '0;
            endcase
        end
        unique case (st.fsm)
            IDLE: begin
                if (wr_i && addr_i == HADR_CMD) begin
                    next_st.tx = {wdata_i[CMD_RD_BIT] ? OP_READ : OP_WRITE,
                                  wdata_i[CMD_ADDR_LO +: ADDR_W],
                                  wdata_i[CMD_DATA_LO +: BYTE_W]};
                    next_st.is_read = wdata_i[CMD_RD_BIT];
                    next_st.busy = 1'b1;
                    next_st.ss_n = 1'b0;
                    next_st.div  = 8'(RECOVER_CYC);
                    next_st.bits = '0;
                    next_st.fsm  = SETUP;
                end
            end
            SETUP: begin
                if (st.div == '0) begin
                    next_st.fsm = HIGH;
                    next_st.div = 8'(HALF_DIV - 1);
                end else begin
                    next_st.div = st.div - 1'b1;
                end
            end
            HIGH: begin
                if (st.div == '0) begin
                    next_st.sck  = 1'b0;
                    next_st.mosi = st.tx[FRAME_BITS-1];
                    next_st.tx   = {st.tx[FRAME_BITS-2:0], 1'b0};
                    next_st.div  = 8'(HALF_DIV - 1);
                    next_st.fsm  = LOW;
                end else begin
                    next_st.div = st.div - 1'b1;
                end
            end
            LOW: begin
                if (st.div == '0) begin
                    next_st.sck  = 1'b1;
                    next_st.cap[0] = 1'b1;
                    next_st.bits = st.bits + 1'b1;
                    next_st.div  = 8'(HALF_DIV - 1);
                    next_st.fsm  = (st.bits == CNT_W'(FRAME_BITS - 1)) ?
                                   HOLD : HIGH;
                    if (st.bits == CNT_W'(FRAME_BITS - 1)) begin
                        next_st.div = 8'(DISABLE_CYC + HALF_DIV);
                    end
                end else begin
                    next_st.div = st.div - 1'b1;
                end
            end
            HOLD: begin
                if (st.div == '0) begin
                    next_st.ss_n = 1'b1;
                    next_st.busy = 1'b0;
                    next_st.fsm  = IDLE;
                end else begin
                    next_st.div = st.div - 1'b1;
                end
            end
        endcase
        // Miso is taken two cycles after the rise to match its synchroniser.
        if (st.cap[1]) begin
            next_st.rx = {st.rx[BYTE_W-2:0], st.miso_sync[1]};
        end
    end

    // ********************************************************************
    // State register
    // ********************************************************************
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st      <= '0;
            st.fsm  <= IDLE;
            st.sck  <= 1'b1;
            st.ss_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign spi.sck  = st.sck;
    assign spi.ss_n = st.ss_n;
    assign spi.mosi = st.mosi;
    assign rdata_o  = st.rdata;
endmodule : sra_spi_host
`default_nettype wire

// [tb/sra_link_asserts.sv]
// Concurrent checks on the serial link between host end and codec end.
`timescale 1ns/1ns
`default_nettype none
module sra_link_asserts (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic miso
);
    import sra_pkg::*;
    // ****************************************************************
    // Helper logic
    // ****************************************************************
    // Counts rising serial clock edges inside one selected frame.
    logic [4:0] rise_cnt;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || ss_n) begin
            rise_cnt <= 5'h00;
        end else if ($rose(sck)) begin
            rise_cnt <= rise_cnt + 5'h01;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // ****************************************************************
    // Link rules
    // ****************************************************************
    a_idle_clock_high: assert property (ss_n |-> sck)
        else $error("serial clock low while slave not selected");
    a_recover_wait: assert property ($fell(ss_n) |-> sck [*8] ##1 sck [*5])
        else $error("first clock fall too soon after select");
    a_clock_half_rate: assert property ($changed(sck) |=> $stable(sck))
        else $error("serial clock level shorter than two cycles");
    a_disable_hold: assert property ($rose(ss_n) |-> $past(sck, 1) && $past(sck, 2))
        else $error("select released too soon after last rise");
    a_mosi_fall_only: assert property (!ss_n && !$past(ss_n) && $changed(mosi) |-> !sck)
        else $error("master data changed while clock high");
    a_miso_fall_only: assert property (!ss_n && $changed(miso) |-> !sck)
        else $error("slave data changed while clock high");
    a_miso_quiet: assert property (ss_n [*4] |-> !miso)
        else $error("slave data driven outside a frame");
    a_frame_length: assert property ($rose(ss_n) |-> rise_cnt == 5'(FRAME_BITS))
        else $error("frame did not hold sixteen clock rises");
    c_frame_end: cover property ($rose(ss_n));
    c_miso_high: cover property (!ss_n && miso);
    c_clock_fall: cover property (!ss_n && $fell(sck));
endmodule : sra_link_asserts
`default_nettype wire

// [tb/tb.sv]
// Testbench: host and codec ends joined, plus a bit-banged second link.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import sra_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [1:0] addr = 2'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0, rd = 1'b0;
    logic fs = 1'b0, fs_q = 1'b0;
    logic loop = 1'b0, seen = 1'b0;
    logic [15:0] adc_s = 16'h0000, sai_s = 16'h0000;
    logic [15:0] rdata, dac_d, lfsr = 16'h105a, off_t = 16'h0000;
    logic adc_f, dac_f, dac_pd, dac_v;
    logic af = 1'b1, df = 1'b1;
    logic [7:0] athr = 8'h00, dthr = 8'h00, on_t = 8'h00, pwr = 8'h00;
    logic [4:0] regs [7] = '{ADR_OFF_LO, ADR_OFF_HI, ADR_ON_TIME,
        ADR_ADC_THR, ADR_DAC_THR, ADR_POWER, 5'h1f};
    logic [7:0] cfg [6] = '{8'h05, 8'h00, 8'h03, 8'h08, 8'h08, 8'h10};
    int ac = 0, dc = 0, fails = 0, checked = 0, cyc = 0;
    sra_spi_if spi ();
    sra_spi_if spi2 ();
    sra_spi_host #(.HALF_DIV(4)) i_sra_spi_host (.sys_clk_i(sys_clk_i),
        .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .spi(spi));
    sra_codec_ctrl i_sra_codec_ctrl (.sys_clk_i(sys_clk_i),
        .reset_i(reset_i), .spi(spi), .frame_sync_i(fs), .adc_sample_i(adc_s),
        .serial_audio_in_i(sai_s), .loopback_i(loop),
        .adc_activity_flag_o(adc_f), .dac_activity_flag_o(dac_f),
        .dac_power_down_o(dac_pd), .dac_data_valid_o(dac_v),
        .dac_data_o(dac_d));
    sra_codec_ctrl i_sra_codec_ctrl_b (.sys_clk_i(sys_clk_i),
        .reset_i(reset_i), .spi(spi2), .frame_sync_i(fs),
        .adc_sample_i(adc_s), .serial_audio_in_i(sai_s), .loopback_i(loop),
        .adc_activity_flag_o(), .dac_activity_flag_o(),
        .dac_power_down_o(), .dac_data_valid_o(), .dac_data_o());
    sra_link_asserts i_sra_link_asserts (.sys_clk_i(sys_clk_i),
        .reset_i(reset_i), .sck(spi.sck), .ss_n(spi.ss_n), .mosi(spi.mosi),
        .miso(spi.miso));
    always #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        fs_q <= fs;
        if (fs && !fs_q) seen <= 1'b0;
        else if (dac_v) seen <= 1'b1;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails = fails + 1;
            finish_test();
        end
    end
    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nxt
    function automatic logic [7:0] mag8(input logic [15:0] s);
        logic [15:0] m;
        m = s[15] ? 16'(-s) : s;
        return m[14:7];
    endfunction : mag8
    function automatic logic [7:0] shadow(input logic [4:0] a);
        case (a)
            ADR_OFF_LO: return off_t[7:0];
            ADR_OFF_HI: return off_t[15:8];
            ADR_ON_TIME: return on_t;
            ADR_ADC_THR: return athr;
            ADR_DAC_THR: return dthr;
            ADR_POWER: return pwr;
            default: return 8'h00;
        endcase
    endfunction : shadow
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check
    task automatic hwr(input logic [1:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask : hwr
    task automatic hrd(input logic [1:0] a, output logic [15:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        @(posedge sys_clk_i);
        d = rdata;
    endtask : hrd
    task automatic xfer(input logic r, input logic [4:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        logic [15:0] s;
        hwr(HADR_CMD, 16'({r, a, d}));
        repeat (2) @(posedge sys_clk_i);
        for (int n = 0; n < 400; n++) begin
            hrd(HADR_STATUS, s);
            if (s[0] === 1'b0) break;
        end
        check(s, 16'h0000);
        hrd(HADR_RDATA, s);
        q = s[7:0];
    endtask : xfer
    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b0, a, d, q);
        case (a)
            ADR_OFF_LO: off_t[7:0] = d;
            ADR_OFF_HI: off_t[15:8] = d;
            ADR_ON_TIME: on_t = d;
            ADR_ADC_THR: athr = d;
            ADR_DAC_THR: dthr = d;
            ADR_POWER: pwr = d;
            default: ;
        endcase
    endtask : wreg
    task automatic rreg(input logic [4:0] a);
        logic [7:0] q;
        lfsr = nxt(lfsr);
        xfer(1'b1, a, lfsr[7:0], q);
        check(16'(q), 16'(shadow(a)));
    endtask : rreg
    // A quiet sample counts only below the threshold; equal clears both.
    task automatic model(input logic [15:0] s, input logic [7:0] t,
                         inout logic f, inout int c);
        if (t == 8'h00 || on_t == 8'h00 || off_t == 16'h0000) begin
            f = 1'b1;
            c = 0;
        end else if (!f) begin
            c = (mag8(s) > t) ? c + 1 : 0;
            if (c == int'(on_t)) begin
                f = 1'b1;
                c = 0;
            end
        end else begin
            c = (mag8(s) < t) ? c + 1 : 0;
            if (c == int'(off_t)) begin
                f = 1'b0;
                c = 0;
            end
        end
    endtask : model
    task automatic sample(input logic [15:0] a, input logic [15:0] d,
                          input logic lb);
        adc_s <= a;
        sai_s <= d;
        loop <= lb;
        repeat (2) @(posedge sys_clk_i);
        fs <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        fs <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        model(a, athr, af, ac);
        model(d, dthr, df, dc);
        check(16'(adc_f), 16'(af));
        check(16'(dac_f), 16'(df));
        check(16'(dac_pd), 16'(pwr[PWR_DAC_SLEEP_BIT] & ~df));
        check(16'(seen), 16'(!lb));
        if (!lb) check(dac_d, d);
    endtask : sample
    // Bit-banged master on the second link; it may stop a frame early.
    task automatic bang(input logic [15:0] w, input int nb,
                        output logic [15:0] q);
        q = 16'h0000;
        spi2.ss_n <= 1'b0;
        repeat (16) @(posedge sys_clk_i);
        for (int i = 0; i < nb; i++) begin
            spi2.sck <= 1'b0;
            spi2.mosi <= w[15-i];
            repeat (8) @(posedge sys_clk_i);
            spi2.sck <= 1'b1;
            q[15-i] = spi2.miso;
            repeat (8) @(posedge sys_clk_i);
        end
        repeat (4) @(posedge sys_clk_i);
        spi2.ss_n <= 1'b1;
        spi2.mosi <= ~spi2.mosi;
        repeat (8) @(posedge sys_clk_i);
    endtask : bang
    task automatic bread(input logic [7:0] e);
        logic [15:0] q;
        bang({OP_READ, ADR_ADC_THR, 8'h00}, 16, q);
        check(16'(q[7:0]), 16'(e));
    endtask : bread
    task automatic finish_test();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin : main
        logic [15:0] q;
        logic [15:0] d;
        spi2.sck = 1'b1;
        spi2.ss_n = 1'b1;
        spi2.mosi = 1'b0;
        repeat (4) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        check(16'({adc_f, dac_f}), 16'h0003);
        for (int i = 0; i < 7; i++) rreg(regs[i]);
        hrd(2'h3, q);
        check(q, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            lfsr = nxt(lfsr);
            wreg(regs[i], lfsr[7:0]);
        end
        for (int i = 0; i < 7; i++) rreg(regs[i]);
        $display("test registers done");
        for (int i = 0; i < 6; i++) wreg(regs[i], cfg[i]);
        for (int i = 0; i < 160; i++) begin
            if (i == 60) wreg(ADR_ON_TIME, 8'h00);
            if (i == 80) wreg(ADR_ON_TIME, 8'h03);
            if (i == 110) wreg(ADR_DAC_THR, 8'h00);
            if (i == 130) wreg(ADR_DAC_THR, 8'h08);
            lfsr = nxt(lfsr);
            q = {{5{lfsr[15]}}, lfsr[10:0]};
            if (i % 16 == 3) q = 16'h0400;
            if (i % 16 == 4) q = 16'hfc00;
            lfsr = nxt(lfsr);
            d = {{5{lfsr[15]}}, lfsr[10:0]};
            sample(q, d, lfsr[12]);
        end
        $display("test detectors done");
        // A frame cut short by select must leave the register alone.
        bang({OP_WRITE, ADR_ADC_THR, 8'h5a}, 12, q);
        bread(8'h00);
        for (int i = 0; i < 8; i++) begin
            if (3'(i) != OP_READ && 3'(i) != OP_WRITE) begin
                bang({3'(i), ADR_ADC_THR, 8'h33}, 16, q);
            end
        end
        bread(8'h00);
        bang({OP_WRITE, ADR_ADC_THR, 8'ha5}, 16, q);
        bread(8'ha5);
        $display("test second link done");
        finish_test();
    end
endmodule : tb
`default_nettype wire
